// ---- logic/cbfc_regs.v ----
// Operation
// - Every stored coefficient is applied as a signed two's-complement number.
// - Tap four is a 12-bit field, bits 11:0, at offset 0x44E.
// - Centre tap five is 18 bits, bits 17:0, of 24-bit register 0x450.
// - Tap six is a 12-bit field, bits 11:0, at offset 0x453.
// - Tap seven is a 12-bit field, bits 11:0, at offset 0x455.
// - Tap eight is a 12-bit field, bits 11:0, at offset 0x457.
// - Readback returns the coefficient field's top bit as zero, rest as written.
// - Reset clears every coefficient register, reserved bits too, to zero.
// - Tap two is a 12-bit signed field at offset 0x44A.
// - Tap nine is a 12-bit signed field at offset 0x459.
// - Channel-B taps apply in both modes; dual-channel mode only sets the filter enable.
`timescale 1ns/1ns
`default_nettype none
`include "cbfc_consts.vh"

module cbfc_regs #(
  parameter ADDR_W = 13
) (
  // Clock and reset
  input  wire               I_REF_CLK,
  input  wire               I_RST_N,
  // Avalon-MM slave
  input  wire [ADDR_W-1:0]  I_AVS_ADDRESS,
  input  wire               I_AVS_READ,
  input  wire               I_AVS_WRITE,
  input  wire [3:0]         I_AVS_BYTEENABLE,
  input  wire [31:0]        I_AVS_WRITEDATA,
  output reg  [31:0]        O_AVS_READDATA,
  output reg                O_AVS_WAITREQUEST,
  // Channel-B filter side
  output wire signed [11:0] O_TAP2_COEF,
  output wire signed [11:0] O_TAP4_COEF,
  output wire signed [17:0] O_CENTER_COEF,
  output wire signed [11:0] O_TAP6_COEF,
  output wire signed [11:0] O_TAP7_COEF,
  output wire signed [11:0] O_TAP8_COEF,
  output wire signed [11:0] O_TAP9_COEF,
  output reg                O_CHB_FILTER_EN,
  output reg                O_COEF_UPDATE
);

  ////////////////////////////////////////////////////////////////////////
  // Byte addresses
  //
  // Register map by word index; the byte address is four times it:
  //   0x44a  tap two      bits 15:12 spare, bits 11:0 coefficient
  //   0x44e  tap four     bits 15:12 spare, bits 11:0 coefficient
  //   0x450  centre tap   bits 23:18 spare, bits 17:0 coefficient
  //   0x453  tap six      bits 15:12 spare, bits 11:0 coefficient
  //   0x455  tap seven    bits 15:12 spare, bits 11:0 coefficient
  //   0x457  tap eight    bits 15:12 spare, bits 11:0 coefficient
  //   0x459  tap nine     bits 15:12 spare, bits 11:0 coefficient
  //   0x460  control      bit 0 dual-channel mode
  //   0x461  status       bit 0 filter enable, bit 1 apply pending,
  //                       bits 15:8 apply count, read only
  // Spare bits are plain storage: they keep and return what was written.
  // Lanes above a register's width are dropped; any other word in the
  // address space reads as zero, with no error response.
  // Everything clears to zero on reset, spare bits included.

  localparam [ADDR_W-1:0] A_TAP2   = {`CBFC_IDX_TAP2, 2'b00};
  localparam [ADDR_W-1:0] A_TAP4   = {`CBFC_IDX_TAP4, 2'b00};
  localparam [ADDR_W-1:0] A_CENTER = {`CBFC_IDX_CENTER, 2'b00};
  localparam [ADDR_W-1:0] A_TAP6   = {`CBFC_IDX_TAP6, 2'b00};
  localparam [ADDR_W-1:0] A_TAP7   = {`CBFC_IDX_TAP7, 2'b00};
  localparam [ADDR_W-1:0] A_TAP8   = {`CBFC_IDX_TAP8, 2'b00};
  localparam [ADDR_W-1:0] A_TAP9   = {`CBFC_IDX_TAP9, 2'b00};
  // Own control and status words sit just above the taps
  localparam [ADDR_W-1:0] A_CTRL   = {`CBFC_IDX_CTRL, 2'b00};
  localparam [ADDR_W-1:0] A_STATUS = {`CBFC_IDX_STATUS, 2'b00};

  ////////////////////////////////////////////////////////////////////////
  // Reset release

  // Two-stage copy of the reset pin
  reg        rst_meta;
  reg        rst_n;

  // Asynchronous assert, synchronous release through two flops
  // Release is timed to the clock so that no register leaves reset on
  // an edge that the pin's own timing might make metastable
  always @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // Decode, readback and status signals
  wire        wr_take;
  wire [6:0]  tap_wr;
  wire [6:0]  applied;
  wire [31:0] rd_tap2;
  wire [31:0] rd_tap4;
  wire [31:0] rd_center;
  wire [31:0] rd_tap6;
  wire [31:0] rd_tap7;
  wire [31:0] rd_tap8;
  wire [31:0] rd_tap9;
  reg  [31:0] next_rdata;
  reg  [31:0] status_word;
  wire        ctrl_wr;
  wire        any_applied;
  reg         dual_mode;
  reg         pending;
  reg  [7:0]  update_cnt;

  // A write takes effect only at the edge where waitrequest is low
  assign wr_take = I_AVS_WRITE && !O_AVS_WAITREQUEST;

  ////////////////////////////////////////////////////////////////////////
  // Write strobes

  // One strobe per tap; the full address is compared, so neighbouring
  // registers owned by other blocks never alias onto these taps
  assign tap_wr[0] = wr_take && (I_AVS_ADDRESS == A_TAP2);
  assign tap_wr[1] = wr_take && (I_AVS_ADDRESS == A_TAP4);
  assign tap_wr[2] = wr_take && (I_AVS_ADDRESS == A_CENTER);
  assign tap_wr[3] = wr_take && (I_AVS_ADDRESS == A_TAP6);
  assign tap_wr[4] = wr_take && (I_AVS_ADDRESS == A_TAP7);
  assign tap_wr[5] = wr_take && (I_AVS_ADDRESS == A_TAP8);
  assign tap_wr[6] = wr_take && (I_AVS_ADDRESS == A_TAP9);

  // Mode bit lives in the low lane only
  assign ctrl_wr = wr_take && (I_AVS_ADDRESS == A_CTRL) &&
                   I_AVS_BYTEENABLE[0];

  // Some tap finishing its apply this cycle
  assign any_applied = |applied;

  ////////////////////////////////////////////////////////////////////////
  // Wait state and read path

  // One wait state per access; read data registered with the answer
  //   edge 0  request sampled with waitrequest high, read data loaded
  //   edge 1  waitrequest sampled low: a write lands, read data stand
  //   edge 2  waitrequest high again, free for the next request
  //   a read and a write are never raised together
  // The fixed wait state costs a cycle per access but keeps the read
  // mux off the path to the bus outputs.
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA    <= 32'h0000_0000;
    end else if ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST) begin
      O_AVS_WAITREQUEST <= 1'b0;
      if (I_AVS_READ) begin
        O_AVS_READDATA <= next_rdata;
      end
    end else begin
      O_AVS_WAITREQUEST <= 1'b1;
    end
  end

  // Read mux; unmapped addresses read as zero
  // The whole address is decoded, so nothing aliases in the gaps
  always @* begin
    case (I_AVS_ADDRESS)
      A_TAP2:   next_rdata = rd_tap2;
      A_TAP4:   next_rdata = rd_tap4;
      A_CENTER: next_rdata = rd_center;
      A_TAP6:   next_rdata = rd_tap6;
      A_TAP7:   next_rdata = rd_tap7;
      A_TAP8:   next_rdata = rd_tap8;
      A_TAP9:   next_rdata = rd_tap9;
      A_CTRL:   next_rdata = {31'h0000_0000, dual_mode};
      A_STATUS: next_rdata = status_word;
      default:  next_rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word

  // Built from the field positions; every spare bit reads as zero
  // Pending and count let software see when an apply has landed
  always @* begin
    status_word                          = 32'h0000_0000;
    status_word[`CBFC_STAT_CNT_LSB +: 8] = update_cnt;
    status_word[`CBFC_STAT_PEND_BIT]     = pending;
    status_word[`CBFC_STAT_DUAL_BIT]     = O_CHB_FILTER_EN;
  end

  ////////////////////////////////////////////////////////////////////////
  // Coefficient registers

  // Tap two: 12-bit field, nibble above it kept as spare storage
  cbfc_tap_reg #(
    .REG_W   (`CBFC_TAP_REG_W),
    .FIELD_W (`CBFC_TAP_FIELD_W)
  ) u_tap2 (
    .i_clk     (I_REF_CLK),
    .i_rst_n   (rst_n),
    .i_wr      (tap_wr[0]),
    .i_be      (I_AVS_BYTEENABLE),
    .i_wdata   (I_AVS_WRITEDATA),
    .o_rdata   (rd_tap2),
    .o_coef    (O_TAP2_COEF),
    .o_applied (applied[0])
  );

  // Tap four
  cbfc_tap_reg #(
    .REG_W   (`CBFC_TAP_REG_W),
    .FIELD_W (`CBFC_TAP_FIELD_W)
  ) u_tap4 (
    .i_clk     (I_REF_CLK),
    .i_rst_n   (rst_n),
    .i_wr      (tap_wr[1]),
    .i_be      (I_AVS_BYTEENABLE),
    .i_wdata   (I_AVS_WRITEDATA),
    .o_rdata   (rd_tap4),
    .o_coef    (O_TAP4_COEF),
    .o_applied (applied[1])
  );

  // Centre tap carries the wider field in a three-byte register
  cbfc_tap_reg #(
    .REG_W   (`CBFC_CTR_REG_W),
    .FIELD_W (`CBFC_CTR_FIELD_W)
  ) u_center (
    .i_clk     (I_REF_CLK),
    .i_rst_n   (rst_n),
    .i_wr      (tap_wr[2]),
    .i_be      (I_AVS_BYTEENABLE),
    .i_wdata   (I_AVS_WRITEDATA),
    .o_rdata   (rd_center),
    .o_coef    (O_CENTER_COEF),
    .o_applied (applied[2])
  );

  // Tap six
  cbfc_tap_reg #(
    .REG_W   (`CBFC_TAP_REG_W),
    .FIELD_W (`CBFC_TAP_FIELD_W)
  ) u_tap6 (
    .i_clk     (I_REF_CLK),
    .i_rst_n   (rst_n),
    .i_wr      (tap_wr[3]),
    .i_be      (I_AVS_BYTEENABLE),
    .i_wdata   (I_AVS_WRITEDATA),
    .o_rdata   (rd_tap6),
    .o_coef    (O_TAP6_COEF),
    .o_applied (applied[3])
  );

  // Tap seven
  cbfc_tap_reg #(
    .REG_W   (`CBFC_TAP_REG_W),
    .FIELD_W (`CBFC_TAP_FIELD_W)
  ) u_tap7 (
    .i_clk     (I_REF_CLK),
    .i_rst_n   (rst_n),
    .i_wr      (tap_wr[4]),
    .i_be      (I_AVS_BYTEENABLE),
    .i_wdata   (I_AVS_WRITEDATA),
    .o_rdata   (rd_tap7),
    .o_coef    (O_TAP7_COEF),
    .o_applied (applied[4])
  );

  // Tap eight
  cbfc_tap_reg #(
    .REG_W   (`CBFC_TAP_REG_W),
    .FIELD_W (`CBFC_TAP_FIELD_W)
  ) u_tap8 (
    .i_clk     (I_REF_CLK),
    .i_rst_n   (rst_n),
    .i_wr      (tap_wr[5]),
    .i_be      (I_AVS_BYTEENABLE),
    .i_wdata   (I_AVS_WRITEDATA),
    .o_rdata   (rd_tap8),
    .o_coef    (O_TAP8_COEF),
    .o_applied (applied[5])
  );

  // Tap nine
  cbfc_tap_reg #(
    .REG_W   (`CBFC_TAP_REG_W),
    .FIELD_W (`CBFC_TAP_FIELD_W)
  ) u_tap9 (
    .i_clk     (I_REF_CLK),
    .i_rst_n   (rst_n),
    .i_wr      (tap_wr[6]),
    .i_be      (I_AVS_BYTEENABLE),
    .i_wdata   (I_AVS_WRITEDATA),
    .o_rdata   (rd_tap9),
    .o_coef    (O_TAP9_COEF),
    .o_applied (applied[6])
  );

  ////////////////////////////////////////////////////////////////////////
  // Mode control and status

  // Channel mode; single-channel leaves these taps unused by the filter
  // The enable is registered so that every filter-side output is a flop;
  // the filter sees a mode change one cycle after the control write
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dual_mode       <= `CBFC_CTRL_RESET;
      O_CHB_FILTER_EN <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        dual_mode <= I_AVS_WRITEDATA[`CBFC_CTRL_DUAL_BIT];
      end
      O_CHB_FILTER_EN <= dual_mode;
    end
  end

  // Pending flag: a new write wins over the apply that clears it
  // A write landing in an apply cycle keeps the flag up, since its own
  // apply is still to come; software polls it before trusting the filter
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pending       <= 1'b0;
      update_cnt    <= 8'h00;
      O_COEF_UPDATE <= 1'b0;
    end else begin
      if (|tap_wr) begin
        pending <= 1'b1;
      end else if (any_applied) begin
        pending <= 1'b0;
      end
      // Counter wraps; software only looks for change
      // Eight bits are plenty to tell one apply from the next
      if (any_applied) begin
        update_cnt <= update_cnt + 8'h01;
      end
      O_COEF_UPDATE <= any_applied;
    end
  end

endmodule // cbfc_regs

`default_nettype wire

// ---- logic/cbfc_consts.vh ----
`ifndef CBFC_CONSTS_VH
`define CBFC_CONSTS_VH

// Register indices (word index, byte address is four times this)
`define CBFC_IDX_TAP2        11'h44a
`define CBFC_IDX_TAP4        11'h44e
`define CBFC_IDX_CENTER      11'h450
`define CBFC_IDX_TAP6        11'h453
`define CBFC_IDX_TAP7        11'h455
`define CBFC_IDX_TAP8        11'h457
`define CBFC_IDX_TAP9        11'h459
`define CBFC_IDX_CTRL        11'h460
`define CBFC_IDX_STATUS      11'h461

// Register and field widths
`define CBFC_TAP_REG_W       16
`define CBFC_TAP_FIELD_W     12
`define CBFC_CTR_REG_W       24
`define CBFC_CTR_FIELD_W     18

// Control and status field positions
`define CBFC_CTRL_DUAL_BIT   0
`define CBFC_STAT_DUAL_BIT   0
`define CBFC_STAT_PEND_BIT   1
`define CBFC_STAT_CNT_LSB    8

// Reset values
`define CBFC_COEF_RESET      32'h0000_0000
`define CBFC_CTRL_RESET      1'h0

`endif

// ---- logic/cbfc_tap_reg.v ----
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// One coefficient register: byte-lane writes, masked readback and a
// separate applied copy that the filter sees
module cbfc_tap_reg #(
  parameter REG_W   = 16,
  parameter FIELD_W = 12
) (
  // Clock and reset
  input  wire                      i_clk,
  input  wire                      i_rst_n,
  // Write access
  input  wire                      i_wr,
  input  wire [3:0]                i_be,
  input  wire [31:0]               i_wdata,
  // Readback and filter side
  output wire [31:0]               o_rdata,
  output reg  signed [FIELD_W-1:0] o_coef,
  output reg                       o_applied
);

  reg [REG_W-1:0] stored;
  reg             wr_d;
  integer         b;

  // Stored value, reserved bits included, lanes picked by byte enables
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stored <= {REG_W{1'b0}};
    end else if (i_wr) begin
      for (b = 0; b < REG_W / 8; b = b + 1) begin
        if (i_be[b]) begin
          stored[b*8 +: 8] <= i_wdata[b*8 +: 8];
        end
      end
    end
  end

  // Top field bit always reads as zero; reserved bits read as written
  assign o_rdata = {{(32-REG_W){1'b0}}, stored[REG_W-1:FIELD_W],
                    1'b0, stored[FIELD_W-2:0]};

  // Applied one cycle after the bus write completes, never mid-write
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_d      <= 1'b0;
      o_coef    <= {FIELD_W{1'b0}};
      o_applied <= 1'b0;
    end else begin
      wr_d      <= i_wr;
      o_applied <= wr_d;
      if (wr_d) begin
        o_coef <= $signed(stored[FIELD_W-1:0]);
      end
    end
  end

endmodule // cbfc_tap_reg

`default_nettype wire

// ---- testbench/cbfc_regs_props.sv ----
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
module cbfc_regs_props #(
  parameter ADDR_W = 13
) (
  // Clock and reset
  input wire logic               I_REF_CLK,
  input wire logic               I_RST_N,
  // Bus
  input wire logic [ADDR_W-1:0]  I_AVS_ADDRESS,
  input wire logic               I_AVS_READ,
  input wire logic               I_AVS_WRITE,
  input wire logic [3:0]         I_AVS_BYTEENABLE,
  input wire logic [31:0]        I_AVS_WRITEDATA,
  input wire logic [31:0]        O_AVS_READDATA,
  input wire logic               O_AVS_WAITREQUEST,
  // Filter side
  input wire logic signed [11:0] O_TAP4_COEF,
  input wire logic               O_CHB_FILTER_EN,
  input wire logic               O_COEF_UPDATE
);
  // Requests taken while the slave stalls; only whole-field writes count
  wire         take   = (I_AVS_READ | I_AVS_WRITE) & O_AVS_WAITREQUEST;
  wire         rd_at  = take & I_AVS_READ;
  wire         wr_t4  = take & I_AVS_WRITE & (I_AVS_ADDRESS == 13'h1138)
                        & (I_AVS_BYTEENABLE[1:0] == 2'h3);
  wire         wr_ctl = take & I_AVS_WRITE & (I_AVS_ADDRESS == 13'h1180)
                        & I_AVS_BYTEENABLE[0];
  logic [11:0] t4_wr;
  logic        ctl_wr;

  // Last whole value sent to tap four and to the mode bit
  always @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      t4_wr  <= 12'h000;
      ctl_wr <= 1'h0;
    end else begin
      if (wr_t4)
        t4_wr <= I_AVS_WRITEDATA[11:0];
      if (wr_ctl)
        ctl_wr <= I_AVS_WRITEDATA[0];
    end
  end

  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  // One wait state, then the stall returns at once
  sequence s_ack;
    !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
  endsequence
  sequence s_pulse;
    O_COEF_UPDATE ##1 !O_COEF_UPDATE;
  endsequence
  property p_ack;
    take |=> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("wait state wrong");
  property p_rd4;
    rd_at && I_AVS_ADDRESS == 13'h1138 |=>
      O_AVS_READDATA[31:16] == 16'h0 && !O_AVS_READDATA[11];
  endproperty
  a_rd4: assert property (p_rd4) else $error("tap4 readback");
  property p_rdc;
    rd_at && I_AVS_ADDRESS == 13'h1140 |=>
      O_AVS_READDATA[31:24] == 8'h0 && !O_AVS_READDATA[17];
  endproperty
  a_rdc: assert property (p_rdc) else $error("centre readback");
  property p_rdu;
    rd_at && I_AVS_ADDRESS == 13'h1130 |=> O_AVS_READDATA == 32'h0;
  endproperty
  a_rdu: assert property (p_rdu) else $error("unmapped read");
  // A new tap value must not reach the filter before the write ends
  property p_t4;
    wr_t4 |=> $stable(O_TAP4_COEF) [*2] ##[1:2] O_TAP4_COEF == t4_wr;
  endproperty
  a_t4: assert property (p_t4) else $error("tap4 apply");
  property p_upd;
    wr_t4 |-> ##[2:4] s_pulse;
  endproperty
  a_upd: assert property (p_upd) else $error("update pulse");
  property p_en;
    wr_ctl |=> ##[1:2] O_CHB_FILTER_EN == ctl_wr;
  endproperty
  a_en: assert property (p_en) else $error("mode enable");
  property p_rst;
    $rose(I_RST_N) |-> O_AVS_WAITREQUEST && O_TAP4_COEF == 12'sh0
      && !O_CHB_FILTER_EN && !O_COEF_UPDATE;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule // cbfc_regs_props

bind cbfc_regs cbfc_regs_props #(.ADDR_W(ADDR_W)) u_props (
  .I_REF_CLK         (I_REF_CLK),
  .I_RST_N           (I_RST_N),
  .I_AVS_ADDRESS     (I_AVS_ADDRESS),
  .I_AVS_READ        (I_AVS_READ),
  .I_AVS_WRITE       (I_AVS_WRITE),
  .I_AVS_BYTEENABLE  (I_AVS_BYTEENABLE),
  .I_AVS_WRITEDATA   (I_AVS_WRITEDATA),
  .O_AVS_READDATA    (O_AVS_READDATA),
  .O_AVS_WAITREQUEST (O_AVS_WAITREQUEST),
  .O_TAP4_COEF       (O_TAP4_COEF),
  .O_CHB_FILTER_EN   (O_CHB_FILTER_EN),
  .O_COEF_UPDATE     (O_COEF_UPDATE)
);
`default_nettype wire

// ---- testbench/test_chan_b_fir_coef_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
module test_chan_b_fir_coef_regs;
  typedef struct packed {
    logic [12:0] a;
    logic [31:0] d, r;
    logic [17:0] c;
  } cbfc_row_t;
  logic               clk, rst_n, rd, wr, wreq, en, upd;
  logic        [12:0] adr;
  logic        [3:0]  be;
  logic        [31:0] wd, rdat, q;
  logic signed [11:0] t2, t4, t6, t7, t8, t9;
  logic signed [17:0] ctr;
  int                 fail_count, checks;
  cbfc_row_t          rows [9];

  cbfc_regs #(.ADDR_W(13)) DUT (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_BYTEENABLE(be),
    .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq),
    .O_TAP2_COEF(t2), .O_TAP4_COEF(t4), .O_CENTER_COEF(ctr),
    .O_TAP6_COEF(t6), .O_TAP7_COEF(t7), .O_TAP8_COEF(t8),
    .O_TAP9_COEF(t9), .O_CHB_FILTER_EN(en), .O_COEF_UPDATE(upd)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Compare tasks, one per kind of result
  task automatic cmp_rd(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp_out(input string n, input logic [17:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  // Hold the request until waitrequest is seen low; no fixed latency
  task automatic xfer(input logic w, input logic [12:0] a,
                      input logic [31:0] d, input logic [3:0] m);
    int n;
    @(posedge clk);
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    be  <= m;
    n = 0;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (wreq === 1'h0)
        break;
    end
    if (wreq !== 1'h0) begin
      fail_count++;
      $display("mismatch waitrequest exp 0 got %b", wreq);
    end
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask

  // Applied value of the tap behind a register address
  function automatic logic [17:0] coef_of(input logic [12:0] a);
    case (a)
      13'h1128: return {6'h0, t2};
      13'h1138: return {6'h0, t4};
      13'h1140: return ctr;
      13'h114c: return {6'h0, t6};
      13'h1154: return {6'h0, t7};
      13'h115c: return {6'h0, t8};
      13'h1164: return {6'h0, t9};
      default:  return 18'h0;
    endcase
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence: table of taps and the control word first, hand-written corner cases after
  initial begin
    {rst_n, rd, wr, adr, be, wd, fail_count, checks} = '0;
    rows = '{'{13'h1128, 32'hffff_fabc, 32'h0000_f2bc, 18'h00abc},
             '{13'h1138, 32'h0000_07ff, 32'h0000_07ff, 18'h007ff},
             '{13'h1140, 32'hffff_ffff, 32'h00fd_ffff, 18'h3ffff},
             '{13'h114c, 32'h1234_5801, 32'h0000_5001, 18'h00801},
             '{13'h1154, 32'h0000_a123, 32'h0000_a123, 18'h00123},
             '{13'h115c, 32'h0000_0fff, 32'h0000_07ff, 18'h00fff},
             '{13'h1164, 32'h0000_c800, 32'h0000_c000, 18'h00800},
             '{13'h1140, 32'h0002_0000, 32'h0000_0000, 18'h20000},
             '{13'h1180, 32'h0000_0001, 32'h0000_0001, 18'h00000}};
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      xfer(1'h1, rows[i].a, rows[i].d, 4'hf);
      xfer(1'h0, rows[i].a, 32'h0, 4'h0);
      cmp_rd("readback", rows[i].r, q);
      repeat (4) @(posedge clk);
      cmp_out("coef", rows[i].c, coef_of(rows[i].a));
    end
    // Negative taps must look negative to the filter
    cmp_out("sign", 18'h3, {16'h0, ctr < 18'sh0, t9 < 12'sh0});
    // Single byte lane into tap four; the filter keeps the true top bit
    xfer(1'h1, 13'h1138, 32'h0000_5a5a, 4'h2);
    repeat (3) @(posedge clk);
    cmp_out("update", 18'h1, {17'h0, upd});
    @(posedge clk);
    cmp_out("update end", 18'h0, {17'h0, upd});
    xfer(1'h0, 13'h1138, 32'h0, 4'h0);
    cmp_rd("byte lane", 32'h0000_52ff, q);
    repeat (4) @(posedge clk);
    cmp_out("byte lane coef", 18'h00aff, {6'h0, t4});
    // Hole below tap four neither stores nor returns data
    xfer(1'h1, 13'h1130, 32'hffff_ffff, 4'hf);
    xfer(1'h0, 13'h1130, 32'h0, 4'h0);
    cmp_rd("unmapped", 32'h0, q);
    // Mode bit drives the channel-B filter enable and its status bit
    xfer(1'h1, 13'h1180, 32'h1, 4'hf);
    repeat (4) @(posedge clk);
    cmp_out("dual", 18'h1, {17'h0, en});
    xfer(1'h0, 13'h1184, 32'h0, 4'h0);
    cmp_rd("status", 32'h0000_0901, q);
    xfer(1'h1, 13'h1180, 32'h0, 4'hf);
    repeat (4) @(posedge clk);
    cmp_out("single", 18'h0, {17'h0, en});
    xfer(1'h1, 13'h1180, 32'h1, 4'hf);
    // Mid-run reset must clear every register, reserved bits too
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    cmp_out("reset mode", 18'h0, {17'h0, en});
    xfer(1'h0, 13'h1184, 32'h0, 4'h0);
    cmp_rd("reset status", 32'h0, q);
    foreach (rows[i]) begin
      xfer(1'h0, rows[i].a, 32'h0, 4'h0);
      cmp_rd("reset value", 32'h0, q);
      cmp_out("reset coef", 18'h0, coef_of(rows[i].a));
    end
    end_sim();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule // test_chan_b_fir_coef_regs
`default_nettype wire
